// [rtl/pfb_pkg.sv]
// Purpose: Constants for the parallel flash bus host controller
// Assumes: 10 MHz clock, byte-wide flash with 17-bit address
// Notes:   Timing counts derived from nanosecond figures
package pfb_pkg;
    // ==========================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS  = 100;
    localparam int ACCESS_NS      = 70;
    localparam int WE_PULSE_NS    = 35;
    localparam int ACCESS_CYC     = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int WE_PULSE_CYC   = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W          = 4;
    localparam logic [CNT_W-1:0] ACCESS_CNT = CNT_W'(ACCESS_CYC);
    localparam logic [CNT_W-1:0] PULSE_CNT  = CNT_W'(WE_PULSE_CYC);
    // ==========================================================
    // Address map
    localparam int ADDR_W          = 17;
    localparam int DATA_W          = 8;
    localparam int SECTOR_HI       = 16;
    localparam int SECTOR_LO       = 15;
    localparam logic [1:0] SECTOR_ZERO  = 2'h0;
    localparam logic [1:0] SECTOR_ONE   = 2'h1;
    localparam logic [1:0] SECTOR_TWO   = 2'h2;
    localparam logic [1:0] SECTOR_THREE = 2'h3;
    // Identification query offsets (A6 low, A1:A0)
    localparam logic [ADDR_W-1:0] ID_MAKER_ADDR   = 17'h00000;
    localparam logic [ADDR_W-1:0] ID_PART_ADDR    = 17'h00001;
    localparam logic [ADDR_W-1:0] ID_PROT_ADDR    = 17'h00002;
    localparam logic [ADDR_W-1:0] ID_CONT_ADDR    = 17'h00003;
    localparam logic [DATA_W-1:0] PROT_YES        = 8'h01;
    localparam logic [DATA_W-1:0] PROT_NO         = 8'h00;
    // ==========================================================
    // Reset values
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
    // ==========================================================
    // Bus controller states
    typedef enum logic [6:0] {
        PFB_IDLE   = 7'b0000001,
        PFB_RD_SET = 7'b0000010,
        PFB_RD_WT  = 7'b0000100,
        PFB_WR_SET = 7'b0001000,
        PFB_WR_PUL = 7'b0010000,
        PFB_WR_END = 7'b0100000,
        PFB_DONE   = 7'b1000000
    } pfb_state_t;
endpackage

// [rtl/pfb_host.sv]
// Purpose: Host-side bus controller driving a byte-wide parallel flash
// Assumes: One request at a time; flash strobes driven from flip-flops
// Notes:   Command sequences are composed by the user as plain writes
`timescale 1ns/1ps
`default_nettype none

// Function
// [RL1] Read: chip select and output gate low, write strobe high; capture data.
// [RL2] Write strobe stays high throughout every read.
// [RL3] Write: chip select and write strobe low, output gate high, drive address/data.
// [RL4] Device suppresses writes under inhibiting strobe levels.
// [RL5] Output gate high while selected: device floats data.
// [RL6] Chip select high: standby, device floats data and ignores inputs.
// [RL7] Device continues program or erase after deselect.
// [RL8] Device starts in array read after power-up or reset.
// [RL9] Device stays in array read until a write changes command register.
// [RL10] Command register has no address; any address feeds its latches.
// [RL11] Top two address bits select one of four 32 Kbyte sectors.
// [RL12] Erase one sector, several sectors, or the whole array.
// [RL13] Identification sequence enters query mode read with normal timing.
// [RL14] Query mode: A1:A0 select maker, part, protection, continuation code.
// [RL15] Protection query: sector from A16:A15, returns 01h or 00h.
// [RL16] Elevated A9 level also enters identification read mode.
// [RL17] Reads during program or erase return status bits.
// [RL18] Program and erase to protected sectors rejected.
// [RL19] All sectors ship unprotected.
// [RL20] Host issues unlock sequence before program or erase commands.
// [RL21] Device ignores strobe pulses shorter than about 5 ns.
// [RL22] Writes held active during power-up are not accepted.
// [RL23] Address latched at later falling edge of write strobe or chip select.
// [RL24] Data latched at earlier rising edge of write strobe or chip select.
// [RL25] Query mode held until host writes the reset command.
// [RL26] Rejected protected-sector requests leave array unchanged, return to array read.
module pfb_host
    import pfb_pkg::*;
(
    input  wire logic              CLK_I,
    input  wire logic              SRST_I,
    input  wire logic              REQ_I,
    input  wire logic              WRITE_I,
    input  wire logic [ADDR_W-1:0] ADDR_I,
    input  wire logic [DATA_W-1:0] WDATA_I,
    output var  logic              BUSY_O,
    output var  logic              DONE_O,
    output var  logic [DATA_W-1:0] RDATA_O,
    output var  logic [1:0]        SECTOR_O,
    output var  logic              CS_N_O,
    output var  logic              OG_N_O,
    output var  logic              WS_N_O,
    output var  logic [ADDR_W-1:0] ADDR_O,
    output var  logic [DATA_W-1:0] DATA_O,
    output var  logic              DATA_OE_O,
    input  wire logic [DATA_W-1:0] DATA_I
);
    // ==========================================================
    // Input synchroniser for the flash data pins
    // Flash drives these pins with no relation to our clock
    logic [DATA_W-1:0] data_s1;
    logic [DATA_W-1:0] data_s2;
    always_ff @(posedge CLK_I) begin
        data_s1 <= DATA_I;
        data_s2 <= data_s1;
    end

    // ==========================================================
    // Bus sequencer
    pfb_state_t        state;
    pfb_state_t        next_state;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  next_cnt;
    logic              cs_n;
    logic              next_cs_n;
    logic              og_n;
    logic              next_og_n;
    logic              ws_n;
    logic              next_ws_n;
    logic              oe;
    logic              next_oe;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] next_addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] next_wdata;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] next_rdata;
    logic              done;
    logic              next_done;
    logic [1:0]        sector;
    logic [1:0]        next_sector;
    // Busy follows the next state so it lines up with the strobes
    logic              busy;
    logic              next_busy;

    always_comb begin
        next_state  = state;
        next_cnt    = cnt;
        next_cs_n   = cs_n;
        next_og_n   = og_n;
        next_ws_n   = ws_n;
        next_oe     = oe;
        next_addr   = addr;
        next_wdata  = wdata;
        next_rdata  = rdata;
        next_done   = 1'b0;
        next_sector = sector;
        case (state)
            PFB_IDLE: begin
                // Strobes parked high: device in standby, pins floated
                next_cs_n = 1'b1; // RL6
                next_og_n = 1'b1;
                next_ws_n = 1'b1;
                next_oe   = 1'b0;
                if (REQ_I) begin
                    // Any address may carry a command word
                    next_addr   = ADDR_I; // RL10
                    next_sector = ADDR_I[SECTOR_HI:SECTOR_LO]; // RL11
                    // Unlock and reset words pass through untouched
                    next_wdata  = WDATA_I; // RL20 RL25
                    next_cnt    = '0;
                    next_cs_n   = 1'b0;
                    if (WRITE_I) begin
                        next_state = PFB_WR_SET;
                    end else begin
                        next_state = PFB_RD_SET;
                    end
                end
            end
            PFB_RD_SET: begin
                // Write strobe never leaves high during a read
                next_og_n  = 1'b0; // RL1
                next_ws_n  = 1'b1; // RL2
                next_state = PFB_RD_WT;
            end
            PFB_RD_WT: begin
                // Wait one extra cycle for the two-stage synchroniser
                next_cnt = cnt + 4'h1;
                if (cnt == ACCESS_CNT) begin
                    next_rdata = data_s2; // RL1
                    next_og_n  = 1'b1; // RL5
                    next_state = PFB_DONE;
                end
            end
            PFB_WR_SET: begin
                // Output gate high, data driven and write strobe low all from the same clock edge
                next_og_n  = 1'b1; // RL3
                next_oe    = 1'b1; // RL3
                next_ws_n  = 1'b0; // RL23
                next_cnt   = '0;
                next_state = PFB_WR_PUL;
            end
            PFB_WR_PUL: begin
                // Pulse is whole clock periods, far above the glitch filter
                next_cnt = cnt + 4'h1; // RL21
                if (cnt + 4'h1 >= PULSE_CNT) begin
                    next_ws_n  = 1'b1; // RL24
                    next_state = PFB_WR_END;
                end
            end
            PFB_WR_END: begin
                // Data held one cycle past write strobe rise for hold time
                next_oe    = 1'b0;
                next_cs_n  = 1'b1;
                next_state = PFB_DONE;
            end
            PFB_DONE: begin
                next_cs_n  = 1'b1;
                next_og_n  = 1'b1;
                next_done  = 1'b1;
                next_state = PFB_IDLE;
            end
            default: begin
                next_state = PFB_IDLE;
            end
        endcase
        // Registered so the busy pin never glitches on a state decode
        next_busy = (next_state != PFB_IDLE);
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            state  <= PFB_IDLE;
            cnt    <= '0;
            cs_n   <= 1'b1;
            og_n   <= 1'b1;
            ws_n   <= 1'b1;
            oe     <= 1'b0;
            addr   <= ADDR_RST;
            wdata  <= DATA_RST;
            rdata  <= DATA_RST;
            done   <= 1'b0;
            sector <= SECTOR_ZERO;
            busy   <= 1'b0;
        end else begin
            state  <= next_state;
            cnt    <= next_cnt;
            cs_n   <= next_cs_n;
            og_n   <= next_og_n;
            ws_n   <= next_ws_n;
            oe     <= next_oe;
            addr   <= next_addr;
            wdata  <= next_wdata;
            rdata  <= next_rdata;
            done   <= next_done;
            sector <= next_sector;
            busy   <= next_busy;
        end
    end

    // ==========================================================
    // Outputs, all registered
    assign CS_N_O    = cs_n;
    assign OG_N_O    = og_n;
    assign WS_N_O    = ws_n;
    assign ADDR_O    = addr;
    assign DATA_O    = wdata;
    assign DATA_OE_O = oe;
    assign RDATA_O   = rdata;
    assign DONE_O    = done;
    assign SECTOR_O  = sector;
    assign BUSY_O    = busy;
endmodule
`default_nettype wire

// [bench/pfb_host_checker.sv]
// Purpose: Bus-cycle checks on the flash host controller
// Assumes: Bound to pfb_host; one clock domain
// Notes:   Sees top module ports only
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker
module pfb_host_checker
    import pfb_pkg::*;
(
    input wire logic              CLK_I,
    input wire logic              SRST_I,
    input wire logic              REQ_I,
    input wire logic              WRITE_I,
    input wire logic              BUSY_O,
    input wire logic              DONE_O,
    input wire logic              CS_N_O,
    input wire logic              OG_N_O,
    input wire logic              WS_N_O,
    input wire logic              DATA_OE_O,
    input wire logic [ADDR_W-1:0] ADDR_O,
    input wire logic [DATA_W-1:0] DATA_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    AST_RD_LEVELS: assert property (!OG_N_O |-> WS_N_O && !CS_N_O) else $error("read strobes wrong");
    AST_WR_LEVELS: assert property (!WS_N_O |-> !CS_N_O && OG_N_O && DATA_OE_O) else $error("write levels");
    AST_RD_DONE: assert property (REQ_I && !BUSY_O && !WRITE_I |-> ##1 !DONE_O [*5] ##1 DONE_O)
        else $error("read done late");
    AST_WR_DONE: assert property (REQ_I && !BUSY_O && WRITE_I |-> ##1 !DONE_O [*4] ##1 DONE_O)
        else $error("write done late");
    AST_WS_WIDTH: assert property ($fell(WS_N_O) |=> WS_N_O && !CS_N_O) else $error("write pulse width");
    AST_NO_FIGHT: assert property (DATA_OE_O |-> OG_N_O && !CS_N_O) else $error("data contention");
    AST_IDLE_OFF: assert property (!BUSY_O |-> CS_N_O && OG_N_O && WS_N_O && !DATA_OE_O)
        else $error("idle strobes");
    AST_HOLD: assert property (!CS_N_O && !$past(CS_N_O) |-> $stable(ADDR_O) && $stable(DATA_O))
        else $error("addr or data moved");
endmodule
bind pfb_host pfb_host_checker chk (
    .CLK_I     (CLK_I),
    .SRST_I    (SRST_I),
    .REQ_I     (REQ_I),
    .WRITE_I   (WRITE_I),
    .BUSY_O    (BUSY_O),
    .DONE_O    (DONE_O),
    .CS_N_O    (CS_N_O),
    .OG_N_O    (OG_N_O),
    .WS_N_O    (WS_N_O),
    .DATA_OE_O (DATA_OE_O),
    .ADDR_O    (ADDR_O),
    .DATA_O    (DATA_O)
);
`default_nettype wire

// [bench/pfb_flash_model.sv]
// Purpose: Behavioural byte-wide flash device
// Assumes: Clockless; codes below are arbitrary values
// Notes:   No programming; array is a fixed pattern
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Device
module pfb_flash_model
    import pfb_pkg::*;
#(
    parameter logic [7:0] ID_CMD = 8'h90,
    parameter logic [7:0] RST_CMD = 8'hf0,
    parameter logic [7:0] UNLOCK_A = 8'haa,
    parameter logic [7:0] UNLOCK_B = 8'h55,
    parameter logic [7:0] MAKER = 8'h11,
    parameter logic [7:0] PART = 8'h22,
    parameter logic [7:0] CONT = 8'h33
)
(
    input  wire logic              cs_n_i,
    input  wire logic              og_n_i,
    input  wire logic              ws_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] data_i,
    output var  logic [DATA_W-1:0] data_o
);
    logic id_mode = 1'b0;
    logic [1:0] step = 2'h0;
    logic [DATA_W-1:0] last = 8'h00;
    logic [ADDR_W-1:0] lat_addr;
    logic [DATA_W-1:0] val;
    wire wr_n = cs_n_i | ws_n_i | ~og_n_i;
    wire rd_en = !cs_n_i && !og_n_i && ws_n_i;
    always @(negedge wr_n) lat_addr = addr_i;
    always @(posedge wr_n) begin
        // A lone ID command word without both unlock words is dropped; the reset word acts alone
        if (data_i == RST_CMD) begin
            id_mode = 1'b0;
            step    = 2'h0;
        end else if (step == 2'h0 && data_i == UNLOCK_A) begin
            step = 2'h1;
        end else if (step == 2'h1 && data_i == UNLOCK_B) begin
            step = 2'h2;
        end else if (step == 2'h2 && data_i == ID_CMD) begin
            id_mode = 1'b1;
            step    = 2'h0;
        end else begin
            step = 2'h0;
        end
    end
    // Sector-protect byte is always clear: all sectors ship open
    assign val = !id_mode ? ({addr_i[16:15], addr_i[5:0]} ^ 8'ha5) :
                 addr_i[1:0] == 2'h0 ? MAKER : addr_i[1:0] == 2'h1 ? PART :
                 addr_i[1:0] == 2'h2 ? PROT_NO : CONT;
    always @(val or rd_en) if (rd_en) last = val;
    // Floating bus shows inverted last byte, never a stale copy
    assign data_o = rd_en ? val : ~last;
endmodule
`default_nettype wire

// [bench/pfb_host_tb.sv]
// Purpose: Self-checking bench for pfb_host with flash model
// Assumes: 10 MHz clock; inputs driven by NBA at rising edge
// Notes:   Each scenario is its own task
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench
module pfb_host_tb
    import pfb_pkg::*;
;
    logic clk = 1'b0, srst = 1'b1, req = 1'b0, wr = 1'b0;
    logic [ADDR_W-1:0] addr = 17'h00000;
    logic [DATA_W-1:0] wdata = 8'h00, rdata, dout, fq;
    logic [1:0] sector;
    logic busy, done, cs_n, og_n, ws_n, oe;
    logic [ADDR_W-1:0] aout;
    int bad_count = 0, checks = 0;
    wire [DATA_W-1:0] bus = oe ? dout : fq;
    always #50 clk = ~clk;
    pfb_host uut (.CLK_I(clk), .SRST_I(srst), .REQ_I(req), .WRITE_I(wr), .ADDR_I(addr),
        .WDATA_I(wdata), .BUSY_O(busy), .DONE_O(done), .RDATA_O(rdata), .SECTOR_O(sector),
        .CS_N_O(cs_n), .OG_N_O(og_n), .WS_N_O(ws_n), .ADDR_O(aout), .DATA_O(dout),
        .DATA_OE_O(oe), .DATA_I(bus));
    pfb_flash_model flash (.cs_n_i(cs_n), .og_n_i(og_n), .ws_n_i(ws_n), .addr_i(aout),
        .data_i(bus), .data_o(fq));
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        int i;
        @(posedge clk);
        req   <= 1'b1;
        wr    <= w;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        req <= 1'b0;
        for (i = 0; i < 10 && done !== 1'b1; i++) @(posedge clk) #1;
        chk("done", {7'h0, done}, 8'h01);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 8'h00);
        chk("rdata", rdata, exp);
        chk("sector", {6'h0, sector}, {6'h0, a[16:15]});
    endtask
    task automatic t_array;
        logic [ADDR_W-1:0] a;
        #1;
        chk("idle", {4'h0, cs_n, og_n, ws_n, busy}, 8'h0e);
        for (int k = 0; k < 8; k++) begin
            a = {k[2:1], k[0] ? 15'h7fff : 15'h0000};
            rd(a, {a[16:15], a[5:0]} ^ 8'ha5);
        end
    endtask
    task automatic t_ident;
        xfer(1'b1, 17'h00555, 8'h90);
        rd(17'h00000, 8'ha5);
        xfer(1'b1, 17'h00555, 8'haa);
        xfer(1'b1, 17'h002aa, 8'h55);
        xfer(1'b1, 17'h1aaaa, 8'h90);
        rd(17'h00000, 8'h11);
        rd(17'h00001, 8'h22);
        rd(17'h18002, PROT_NO);
        rd(17'h0ff83, 8'h33);
        xfer(1'b1, 17'h00555, 8'hf0);
        rd(17'h08021, 8'h61 ^ 8'ha5);
    endtask
    // Reset lands in mid-read; the host must park and serve again
    task automatic t_reset;
        @(posedge clk);
        req  <= 1'b1;
        wr   <= 1'b0;
        addr <= 17'h10005;
        @(posedge clk);
        req <= 1'b0;
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk("rst_idle", {4'h0, cs_n, og_n, ws_n, busy}, 8'h0e);
        rd(17'h10005, 8'h85 ^ 8'ha5);
    endtask
    task automatic results;
        if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        t_array();
        t_ident();
        t_reset();
        results();
    end
    // Whole run needs about 140 cycles
    initial begin
        repeat (2000) @(posedge clk);
        bad_count++;
        results();
    end
endmodule
`default_nettype wire
